// ===== verilog/cif_core_irq.sv
// Interrupt sequencer, return stack index and status flag register of the core
`timescale 1ns/100ps
`default_nettype none

import cif_pkg::*;

module cif_core_irq #(
	parameter int STACK_LEVELS = cif_pkg::CIF_STACK_LEVELS
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire logic              i_ext_irq_n,
	input  wire logic              i_timer0_ovf,
	input  wire logic              i_timer1_ovf,
	input  wire cif_pkg::cif_core_ev_t i_core_ev,
	input  wire cif_pkg::cif_alu_req_t i_alu,
	input  wire logic              i_reg_we,
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic [7:0]        i_reg_wdata,
	output logic [7:0]             o_reg_rdata,
	output logic [7:0]             o_alu_result,
	output logic                   o_irq_take,
	output logic [14:0]            o_irq_vector,
	output logic                   o_stack_full,
	output logic                   o_wake,
	output logic [7:0]             o_status,
	output logic [7:0]             o_irq_control
);
	import cif_pkg::*;

	localparam int SPW = $clog2(STACK_LEVELS + 1);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]     status;
		logic [7:0]     irq_control;
		logic [SPW-1:0] depth;
		logic           ext_pin;
		logic           take;
		logic [14:0]    vector;
		logic           wake;
		logic [7:0]     rdata;
		logic [7:0]     result;
		logic           full;
	} cif_state_t;

	cif_state_t s_q;
	cif_state_t s_d;

	// ==========================================================
	// Arithmetic unit
	// Flag computation shared by every arithmetic path
	function automatic logic [12:0] alu_calc(input cif_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] sum;
		logic [4:0] lo;
		logic [7:0] bb;
		logic       ci;
		logic       c7;
		logic [7:0] r;
		logic       c;
		logic       h;
		logic       v;
		logic       arith;
		logic       upd_c;
		sum   = 9'h000;
		lo    = 5'h00;
		bb    = b;
		ci    = 1'b0;
		c7    = 1'b0;
		r     = 8'h00;
		c     = cin;
		h     = 1'b0;
		v     = 1'b0;
		arith = 1'b0;
		upd_c = 1'b0;
		unique case (op)
			CIF_OP_ADD, CIF_OP_ADC, CIF_OP_SUB, CIF_OP_SBC, CIF_OP_INC, CIF_OP_DEC: begin
				arith = 1'b1;
				if (op == CIF_OP_ADD) begin
					ci = 1'b0;
				end else if (op == CIF_OP_ADC) begin
					ci = cin;
				end else if (op == CIF_OP_SUB) begin
					bb = ~b;
					ci = 1'b1;
				end else if (op == CIF_OP_SBC) begin
					bb = ~b;
					ci = cin;
				end else if (op == CIF_OP_INC) begin
					bb = 8'h01;
				end else begin
					bb = 8'hFF;
				end
				// Subtraction as a + ~b + 1: carry out means no borrow
				sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
				lo  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
				c7  = a[7] ^ bb[7] ^ sum[7];
				r   = sum[7:0];
				h   = lo[4];
				v   = c7 ^ sum[8];
				upd_c = (op != CIF_OP_INC) && (op != CIF_OP_DEC);
				if (upd_c) begin
					c = sum[8];
				end
			end
			CIF_OP_AND: r = a & b;
			CIF_OP_OR:  r = a | b;
			CIF_OP_XOR: r = a ^ b;
			CIF_OP_CPL: r = ~a;
			CIF_OP_RLC: begin
				r = {a[6:0], cin};
				c = a[7];
			end
			CIF_OP_RRC: begin
				r = {cin, a[7:1]};
				c = a[0];
			end
			CIF_OP_RL: r = {a[6:0], a[7]};
			CIF_OP_RR: r = {a[0], a[7:1]};
			CIF_OP_NONE: r = a;
			// Spare opcode passes the operand through untouched
			default: r = a;
		endcase
		// Bits: result, carry, half, overflow, arith, constant zero
		alu_calc = {r, c, h, v, arith, 1'b0};
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		logic [12:0] alu_o;
		logic        fall;
		logic        ext_p;
		logic        t0_p;
		logic        t1_p;
		logic        room;
		logic        ret_any;
		logic [SPW-1:0] dep;
		alu_o   = 13'h0000;
		fall    = 1'b0;
		ext_p   = 1'b0;
		t0_p    = 1'b0;
		t1_p    = 1'b0;
		room    = 1'b0;
		ret_any = 1'b0;
		dep     = s_q.depth;
		s_d     = s_q;
		s_d.take = 1'b0;
		s_d.ext_pin = i_ext_irq_n;

		// Software writes first, so hardware events below win over them
		if (i_reg_we && i_reg_addr == CIF_ADDR_STATUS) begin
			s_d.status[3:0] = i_reg_wdata[3:0];
		end
		if (i_reg_we && i_reg_addr == CIF_ADDR_IRQ_CONTROL) begin
			s_d.irq_control[6:0] = i_reg_wdata[6:0];
		end

		// ==========================================================
		// Zero follows every operation; carry only ADD, ADC, SUB, SBC, RLC, RRC; half and wrap the arithmetic ones
		if (i_alu.valid) begin
			alu_o = alu_calc(i_alu.op, i_alu.a, i_alu.b, s_q.status[CIF_ST_CARRY]);
			s_d.result = alu_o[12:5];
			s_d.status[CIF_ST_CARRY] = alu_o[4];
			s_d.status[CIF_ST_ZERO]  = (alu_o[12:5] == 8'h00);
			if (alu_o[1]) begin
				s_d.status[CIF_ST_HALF] = alu_o[3];
				s_d.status[CIF_ST_WRAP] = alu_o[2];
			end
		end

		// ==========================================================
		// Power-down and expiry flags; only core events move them
		if (i_core_ev.halt) begin
			s_d.status[CIF_ST_PDF] = 1'b1;
			s_d.status[CIF_ST_WDX] = 1'b0;
		end
		if (i_core_ev.wdt_clear) begin
			s_d.status[CIF_ST_PDF] = 1'b0;
			s_d.status[CIF_ST_WDX] = 1'b0;
		end
		if (i_core_ev.wdt_timeout) begin
			s_d.status[CIF_ST_WDX] = 1'b1;
		end
		s_d.status[7:6] = 2'b00;

		// ==========================================================
		// Return stack depth; only the PC is pushed, core handles contents
		ret_any = i_core_ev.ret || i_core_ev.return_from_irq_op;
		if (ret_any && dep != '0) begin
			dep = dep - 1'b1;
		end
		if (i_core_ev.call && dep != SPW'(STACK_LEVELS)) begin
			dep = dep + 1'b1;
		end
		if (i_core_ev.return_from_irq_op) begin
			s_d.irq_control[CIF_IC_MASTER] = 1'b1;
		end

		// ==========================================================
		// Acknowledge uses registered flags; full stack holds everything off unless a return comes in the same cycle
		room  = (s_q.depth != SPW'(STACK_LEVELS)) || ret_any;
		ext_p = s_q.irq_control[CIF_IC_EXT_EN] && s_q.irq_control[CIF_IC_EXT_RQ];
		t0_p  = s_q.irq_control[CIF_IC_T0_EN] && s_q.irq_control[CIF_IC_T0_RQ];
		t1_p  = s_q.irq_control[CIF_IC_T1_EN] && s_q.irq_control[CIF_IC_T1_RQ];
		if (s_q.irq_control[CIF_IC_MASTER] && room && !i_core_ev.call && (ext_p || t0_p || t1_p)) begin
			s_d.take = 1'b1;
			s_d.irq_control[CIF_IC_MASTER] = 1'b0;
			dep = dep + 1'b1;
			if (ext_p) begin
				s_d.vector = CIF_VEC_EXT;
				s_d.irq_control[CIF_IC_EXT_RQ] = 1'b0;
			end else if (t0_p) begin
				s_d.vector = CIF_VEC_T0;
				s_d.irq_control[CIF_IC_T0_RQ] = 1'b0;
			end else begin
				s_d.vector = CIF_VEC_T1;
				s_d.irq_control[CIF_IC_T1_RQ] = 1'b0;
			end
		end

		// ==========================================================
		// Request capture after the acknowledge: a request arriving in the
		// cycle of its own acknowledge is kept instead of being lost, and
		// a same-cycle software clear loses as well
		fall = s_q.ext_pin && !i_ext_irq_n;
		if (fall) begin
			s_d.irq_control[CIF_IC_EXT_RQ] = 1'b1;
		end
		if (i_timer0_ovf) begin
			s_d.irq_control[CIF_IC_T0_RQ] = 1'b1;
		end
		if (i_timer1_ovf) begin
			s_d.irq_control[CIF_IC_T1_RQ] = 1'b1;
		end
		s_d.depth   = dep;
		// Full flag registered so the output comes straight from a flop
		s_d.full    = (dep == SPW'(STACK_LEVELS));
		s_d.irq_control[7] = 1'b0;

		// Wake on any request, enabled or not, while powered down
		s_d.wake = s_q.status[CIF_ST_PDF] && (fall || i_timer0_ovf || i_timer1_ovf);

		// ==========================================================
		// Registered read port
		unique case (i_reg_addr)
			CIF_ADDR_STATUS: s_d.rdata = {2'b00, s_d.status[5:0]};
			CIF_ADDR_IRQ_CONTROL:   s_d.rdata = {1'b0, s_d.irq_control[6:0]};
			default:         s_d.rdata = 8'h00;
		endcase
	end

	// ==========================================================
	// State register; reset clears enables and flags
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{status: CIF_RST_REG, irq_control: CIF_RST_REG, depth: '0, ext_pin: 1'b1,
				take: 1'b0, vector: 15'h0000, wake: 1'b0, rdata: 8'h00,
				result: 8'h00, full: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign o_reg_rdata   = s_q.rdata;
	assign o_alu_result  = s_q.result;
	assign o_irq_take    = s_q.take;
	assign o_irq_vector  = s_q.vector;
	assign o_stack_full  = s_q.full;
	assign o_wake        = s_q.wake;
	assign o_status      = s_q.status;
	assign o_irq_control = s_q.irq_control;

endmodule : cif_core_irq

`default_nettype wire

// ===== verilog/cif_pkg.sv
// Package for the core interrupt sequencer and status flag block
package cif_pkg;

	// ==========================================================
	// Register addresses in data memory
	localparam logic [7:0] CIF_ADDR_STATUS = 8'h0A;
	localparam logic [7:0] CIF_ADDR_IRQ_CONTROL   = 8'h0B;

	// ==========================================================
	// Status register bit positions
	localparam int CIF_ST_CARRY = 0;
	localparam int CIF_ST_HALF  = 1;
	localparam int CIF_ST_ZERO  = 2;
	localparam int CIF_ST_WRAP  = 3;
	localparam int CIF_ST_PDF   = 4;
	localparam int CIF_ST_WDX   = 5;

	// ==========================================================
	// Interrupt control bit positions
	localparam int CIF_IC_MASTER = 0;
	localparam int CIF_IC_EXT_EN = 1;
	localparam int CIF_IC_T0_EN  = 2;
	localparam int CIF_IC_T1_EN  = 3;
	localparam int CIF_IC_EXT_RQ = 4;
	localparam int CIF_IC_T0_RQ  = 5;
	localparam int CIF_IC_T1_RQ  = 6;

	// ==========================================================
	// Vectors, reset values, stack depth
	localparam logic [14:0] CIF_VEC_EXT  = 15'h0004;
	localparam logic [14:0] CIF_VEC_T0   = 15'h0008;
	localparam logic [14:0] CIF_VEC_T1   = 15'h000C;
	localparam logic [7:0]  CIF_RST_REG  = 8'h00;
	localparam int          CIF_STACK_LEVELS = 8;

	// ==========================================================
	// Arithmetic operations
	typedef enum logic [3:0] {
		CIF_OP_NONE, CIF_OP_ADD, CIF_OP_ADC, CIF_OP_SUB, CIF_OP_SBC,
		CIF_OP_AND, CIF_OP_OR, CIF_OP_XOR, CIF_OP_CPL, CIF_OP_INC,
		CIF_OP_DEC, CIF_OP_RLC, CIF_OP_RRC, CIF_OP_RL, CIF_OP_RR
	} cif_op_t;

	// ALU request bundle
	typedef struct packed {
		logic    valid;
		cif_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} cif_alu_req_t;

	// Core instruction strobes
	typedef struct packed {
		logic call;
		logic ret;
		logic return_from_irq_op;
		logic halt;
		logic wdt_clear;
		logic wdt_timeout;
	} cif_core_ev_t;

endpackage : cif_pkg

// ===== dv/cif_core_irq_props.sv
// Checker for the interrupt sequencer and status flag block
`timescale 1ns/100ps
`default_nettype none
module cif_core_irq_props (
	input wire logic                  i_clk_sys,
	input wire logic                  i_rst_n,
	input wire logic                  i_ext_irq_n,
	input wire logic                  i_timer0_ovf,
	input wire logic                  i_timer1_ovf,
	input wire cif_pkg::cif_core_ev_t i_core_ev,
	input wire logic                  i_reg_we,
	input wire logic [7:0]            i_reg_addr,
	input wire logic                  o_irq_take,
	input wire logic [14:0]           o_irq_vector,
	input wire logic                  o_stack_full,
	input wire logic                  o_wake,
	input wire logic [7:0]            o_status,
	input wire logic [7:0]            o_irq_control
);
	import cif_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================
	// Request capture, entry and refusal
	property p_ext; $fell(i_ext_irq_n) |=> o_irq_control[4]; endproperty
	property p_t0; i_timer0_ovf |=> o_irq_control[5]; endproperty
	property p_t1; i_timer1_ovf ##1 1'b1 |-> o_irq_control[6]; endproperty
	property p_entry; o_irq_take |-> !o_irq_control[0] && $past(o_irq_control[0]); endproperty
	property p_full; o_stack_full && !i_core_ev.ret && !i_core_ev.return_from_irq_op |=> !o_irq_take; endproperty
	property p_prio;
		o_irq_take && $past(o_irq_control[4] & o_irq_control[1]) |-> o_irq_vector == 15'h0004;
	endproperty
	// ==========================================================
	// Status register
	property p_unused; o_status[7:6] == 2'b00 && !o_irq_control[7]; endproperty
	property p_keep;
		i_reg_we && i_reg_addr == 8'h0A && i_core_ev[2:0] == 3'b000 |=> $stable(o_status[5:4]);
	endproperty
	property p_halt; i_core_ev[2:0] == 3'b100 |=> o_status[5:4] == 2'b01; endproperty
	property p_wake; o_wake |-> $past(o_status[4]); endproperty
	a_ext: assert property (p_ext) else $error("ext flag not set");
	a_t0: assert property (p_t0) else $error("timer0 flag not set");
	a_t1: assert property (p_t1) else $error("timer1 flag not set");
	a_entry: assert property (p_entry) else $error("master not cleared");
	a_full: assert property (p_full) else $error("take on full stack");
	a_prio: assert property (p_prio) else $error("wrong priority");
	a_unused: assert property (p_unused) else $error("unused bit set");
	a_keep: assert property (p_keep) else $error("write hit power flags");
	a_halt: assert property (p_halt) else $error("halt flags wrong");
	a_wake: assert property (p_wake) else $error("wake without halt");
	c_t1: cover property (o_irq_take && o_irq_vector == 15'h000C);
	c_wake: cover property (o_wake);
	c_full: cover property (o_stack_full ##1 o_irq_take);
endmodule // cif_core_irq_props
`default_nettype wire

// ===== dv/cif_core_model.sv
// Core-side model: answers a taken interrupt with a return after a delay
`timescale 1ns/100ps
`default_nettype none
module cif_core_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_take,
	input  wire logic       i_auto,
	input  wire logic [3:0] i_delay,
	output logic            o_return_from_irq_op
);
	logic [3:0] cnt_q;
	logic       busy_q;
	// Service routine length, then one return pulse; a slow core uses a long delay
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			o_return_from_irq_op <= 1'b0;
		end else begin
			o_return_from_irq_op <= busy_q && cnt_q == 4'h0;
			busy_q <= (i_take && i_auto) || (busy_q && cnt_q != 4'h0);
			cnt_q <= (i_take && i_auto) ? i_delay : cnt_q - 4'h1;
		end
	end
endmodule // cif_core_model
`default_nettype wire

// ===== dv/test_cif_core_irq.sv
// Testbench of the interrupt sequencer and status flag block
`timescale 1ns/100ps
`default_nettype none
module test_cif_core_irq;
	import cif_pkg::*;
	logic clk = 0, rst_n = 0, ext_n = 1, t0 = 0, t1 = 0, we = 0, auto = 1, return_from_irq_op, take, full, wake;
	logic [7:0] addr = 0, wdata = 0, rdata, res, st, ic;
	logic [14:0] vec;
	cif_core_ev_t ev = '0;
	cif_alu_req_t alu = '0;
	int n_errors = 0, n_tests = 0, i;
	logic [7:0] ta[3] = '{8'hFF, 8'h7F, 8'h05}, tb[3] = '{8'h01, 8'h01, 8'h03};
	logic [7:0] tr[3] = '{8'h00, 8'h80, 8'h02}, ts[3] = '{8'h07, 8'h0A, 8'h03};
	logic [7:0] ti[3] = '{8'h6E, 8'h4E, 8'h0E};
	logic [14:0] tv[3] = '{15'h0004, 15'h0008, 15'h000C};
	always #2.5 clk = ~clk;
	cif_core_irq DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ext_irq_n(ext_n), .i_timer0_ovf(t0),
		.i_timer1_ovf(t1), .i_core_ev(ev | {2'b00, return_from_irq_op, 3'b000}), .i_alu(alu), .i_reg_we(we),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_alu_result(res),
		.o_irq_take(take), .o_irq_vector(vec), .o_stack_full(full), .o_wake(wake),
		.o_status(st), .o_irq_control(ic));
	cif_core_model u_core (.i_clk_sys(clk), .i_rst_n(rst_n), .i_take(take), .i_auto(auto),
		.i_delay(4'h6), .o_return_from_irq_op(return_from_irq_op));
	// ==========================================================
	// Access tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		we = 1;
		addr = a;
		wdata = d;
		cyc(1);
		we = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		cyc(1);
		chk(rdata, exp);
	endtask
	task automatic pulse(input cif_core_ev_t e);
		ev = e;
		cyc(1);
		ev = '0;
	endtask
	// One ALU strobe, then result and status compared
	task automatic op_chk(input cif_op_t op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] r, input logic [7:0] s);
		alu = '{1'b1, op, a, b};
		cyc(1);
		alu.valid = 0;
		chk(res, r);
		rd(8'h0A, s);
	endtask
	// Bounded wait for a take, then compare its vector
	task automatic wt(input logic [14:0] v);
		for (i = 0; i < 40 && take !== 1'b1; i++) cyc(1);
		chk(take, 1'b1);
		chk(vec, v);
	endtask
	task automatic report_and_stop;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(3000);
		n_errors++;
		report_and_stop;
	end
	// ==========================================================
	// Main sequence
	initial begin
		cyc(12);
		rst_n = 1;
		rd(8'h0A, 8'h00);
		rd(8'h0B, 8'h00);
		// ADD, ADD, SUB with result and flags
		for (int k = 0; k < 3; k++) begin
			alu = '{1'b1, (k == 2) ? CIF_OP_SUB : CIF_OP_ADD, ta[k], tb[k]};
			cyc(1);
			alu.valid = 0;
			chk(res, tr[k]);
			rd(8'h0A, ts[k]);
		end
		// Remaining operations; carry in comes from the previous step
		op_chk(CIF_OP_ADC, 8'h10, 8'h20, 8'h31, 8'h00);
		op_chk(CIF_OP_SBC, 8'h10, 8'h01, 8'h0E, 8'h01);
		op_chk(CIF_OP_INC, 8'hFF, 8'h00, 8'h00, 8'h07);
		op_chk(CIF_OP_DEC, 8'h80, 8'h00, 8'h7F, 8'h09);
		op_chk(CIF_OP_RLC, 8'h01, 8'h00, 8'h03, 8'h08);
		op_chk(CIF_OP_RRC, 8'h03, 8'h00, 8'h01, 8'h09);
		op_chk(CIF_OP_RL, 8'h81, 8'h00, 8'h03, 8'h09);
		op_chk(CIF_OP_RR, 8'h01, 8'h00, 8'h80, 8'h09);
		op_chk(CIF_OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h0D);
		op_chk(CIF_OP_OR, 8'h30, 8'h03, 8'h33, 8'h09);
		op_chk(CIF_OP_XOR, 8'hA5, 8'hA5, 8'h00, 8'h0D);
		op_chk(CIF_OP_CPL, 8'h0F, 8'h00, 8'hF0, 8'h09);
		op_chk(CIF_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h03);
		pulse(6'b000100);
		rd(8'h0A, 8'h13);
		pulse(6'b000001);
		rd(8'h0A, 8'h33);
		wr(8'h0A, 8'hFF);
		rd(8'h0A, 8'h3F);
		pulse(6'b000100);
		rd(8'h0A, 8'h1F);
		ext_n = 0;
		for (i = 0; i < 8 && wake !== 1'b1; i++) cyc(1);
		chk(wake, 1'b1);
		ext_n = 1;
		pulse(6'b000010);
		rd(8'h0A, 8'h0F);
		rd(8'h0B, 8'h10);
		wr(8'h0B, 8'h8E);
		{t0, t1, ext_n} = 3'b110;
		cyc(1);
		{t0, t1, ext_n} = 3'b001;
		rd(8'h0B, 8'h7E);
		wr(8'h0B, 8'hFF);
		// All three pending: served in order, one per return
		for (int k = 0; k < 3; k++) begin
			wt(tv[k]);
			chk(ic, ti[k]);
			cyc(1);
		end
		cyc(10);
		rd(8'h0B, 8'h0F);
		auto = 0;
		wr(8'h0B, 8'h05);
		// Eight back-to-back calls; strobe held high rather than re-raised
		ev = 6'b100000;
		cyc(8);
		ev = '0;
		chk(full, 1'b1);
		t0 = 1;
		cyc(1);
		t0 = 0;
		for (int k = 0; k < 8; k++) begin
			chk(take, 1'b0);
			cyc(1);
		end
		rd(8'h0B, 8'h25);
		pulse(6'b010000);
		wt(15'h0008);
		cyc(1);
		pulse(6'b010000);
		rd(8'h0B, 8'h04);
		report_and_stop;
	end
endmodule // test_cif_core_irq
bind cif_core_irq cif_core_irq_props u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_ext_irq_n(i_ext_irq_n), .i_timer0_ovf(i_timer0_ovf), .i_timer1_ovf(i_timer1_ovf),
	.i_core_ev(i_core_ev), .i_reg_we(i_reg_we), .i_reg_addr(i_reg_addr),
	.o_irq_take(o_irq_take), .o_irq_vector(o_irq_vector), .o_stack_full(o_stack_full),
	.o_wake(o_wake), .o_status(o_status), .o_irq_control(o_irq_control));
`default_nettype wire
